// file: hdl/hare_top.sv
// attribute record encoder: serves health structure bytes on request
// assumes: host logic reads one byte per cycle by index; events are pulses
`default_nettype none
module hare_top
  import hare_pkg::*;
#(
  parameter logic [7:0] SEG_TOTAL = SEG_TOTAL_DEF,
  // per-slot flag words, one 16-bit word per supported identifier
  parameter logic [NUM_SUPPORTED*16-1:0] SLOT_FLAGS = '0
)(
  input  wire logic                     CLK_I,
  input  wire logic                     RST_I,
  input  wire logic [NUM_SUPPORTED-1:0] RAW_INC_I,
  input  wire logic [NUM_SUPPORTED-1:0] NORM_WR_I,
  input  wire logic [7:0]               NORM_I,
  input  wire logic                     AUTO_EN_I,
  input  wire logic                     OFL_START_I,
  input  wire logic                     OFL_SEG_DONE_I,
  input  wire logic                     OFL_SUSPEND_I,
  input  wire logic                     OFL_ABORT_CMD_I,
  input  wire logic                     OFL_FATAL_I,
  input  wire logic                     RD_I,
  input  wire logic [8:0]               RD_ADDR_I,
  output logic                          RD_VALID_O,
  output logic [7:0]                    RD_DATA_O,
  output logic [7:0]                    OFL_STATUS_O,
  output logic [7:0]                    SEG_PTR_O
);
  // ****************************************************************
  // attribute slots
  // ****************************************************************
  logic [47:0] raw_w   [NUM_SUPPORTED];
  logic [7:0]  norm_w  [NUM_SUPPORTED];
  logic [7:0]  worst_w [NUM_SUPPORTED];

  for (genvar g = 0; g < NUM_SUPPORTED; g++) begin : g_slot
    hare_slot u_slot (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .raw_inc_i (RAW_INC_I[g]),
      .norm_wr_i (NORM_WR_I[g]),
      .norm_i    (NORM_I),
      .raw_o     (raw_w[g]),
      .norm_o    (norm_w[g]),
      .worst_o   (worst_w[g])
    );
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    hare_ofl_st_t st;
    logic [6:0]   code;
    logic [7:0]   seg;
    logic         auto_en;
    logic         rd_v;
    logic [7:0]   rd_d;
  } hare_top_st_t;

  hare_top_st_t st_ff;
  hare_top_st_t nxt_st;

  // ****************************************************************
  // byte encoder for the attribute table
  // ****************************************************************
  function automatic logic [7:0] entry_byte(input logic [8:0] addr,
                                            input logic [47:0] raw,
                                            input logic [7:0] nv,
                                            input logic [7:0] wv,
                                            input logic [15:0] fl,
                                            input logic [7:0] id);
    logic [3:0] pos;
    logic [8:0] off;
    off = addr - 9'(TABLE_FIRST_BYTE);
    pos = 4'(off % 9'(ENTRY_BYTES));
    entry_byte = RSVD_BYTE;
    unique case (pos)
      4'(POS_ID):      entry_byte = id;
      4'(POS_FLAG_LO): entry_byte = fl[7:0];
      4'(POS_FLAG_HI): entry_byte = fl[15:8];
      4'(POS_NORM):    entry_byte = nv;
      4'(POS_WORST):   entry_byte = wv;
      4'(POS_RSVD):    entry_byte = RSVD_BYTE;
      default:         entry_byte = raw[8*(pos-4'(POS_RAW_LO)) +: 8];
    endcase
  endfunction

  logic [8:0]  off_w;
  logic [4:0]  ent_w;
  logic [15:0] flag_w;
  logic [7:0]  tbl_byte;

  always_comb begin
    off_w    = RD_ADDR_I - 9'(TABLE_FIRST_BYTE);
    ent_w    = 5'(off_w / 9'(ENTRY_BYTES));
    flag_w   = '0;
    tbl_byte = RSVD_BYTE;
    // unpopulated entries beyond the supported set read as all zero
    if (ent_w < 5'(NUM_SUPPORTED)) begin
      flag_w   = SLOT_FLAGS[16*ent_w +: 16] & FLAG_USED_MASK;
      tbl_byte = entry_byte(RD_ADDR_I, raw_w[ent_w], norm_w[ent_w], worst_w[ent_w],
                            flag_w, SUP_IDS[ent_w]);
    end
  end

  // ****************************************************************
  // off-line collection tracker and read port
  // ****************************************************************
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.auto_en = AUTO_EN_I;
    unique case (st_ff.st)
      HARE_IDLE, HARE_HOLD: begin
        if (OFL_START_I) begin
          nxt_st.st   = HARE_RUN;
          nxt_st.code = OFL_BUSY;
          // a suspended run resumes where it stopped
          if (st_ff.code != OFL_SUSP) nxt_st.seg = SEG_ZERO;
        end
      end
      HARE_RUN: begin
        // fatal error outranks interruption, which outranks progress
        if (OFL_FATAL_I) begin
          nxt_st.st   = HARE_HOLD;
          nxt_st.code = OFL_ABORT_ERR;
        end else if (OFL_ABORT_CMD_I) begin
          nxt_st.st   = HARE_HOLD;
          nxt_st.code = OFL_ABORT_CMD;
        end else if (OFL_SUSPEND_I) begin
          nxt_st.st   = HARE_HOLD;
          nxt_st.code = OFL_SUSP;
        end else if (OFL_SEG_DONE_I) begin
          nxt_st.seg = st_ff.seg + ONE8;
          if (st_ff.seg + ONE8 >= SEG_TOTAL) begin
            nxt_st.seg  = SEG_TOTAL;
            nxt_st.st   = HARE_HOLD;
            nxt_st.code = OFL_DONE;
          end
        end
      end
    endcase

    nxt_st.rd_v = RD_I;
    nxt_st.rd_d = st_ff.rd_d;
    if (RD_I) begin
      nxt_st.rd_d = '0;
      if (RD_ADDR_I >= 9'(TABLE_FIRST_BYTE) && RD_ADDR_I <= 9'(TABLE_LAST_BYTE))
        nxt_st.rd_d = tbl_byte;
    end

    if (RST_I) begin
      nxt_st.st      = HARE_IDLE;
      nxt_st.code    = OFL_NEVER;
      nxt_st.seg     = SEG_ZERO;
      nxt_st.auto_en = 1'b0;
      nxt_st.rd_v    = 1'b0;
      nxt_st.rd_d    = '0;
    end
  end

  always_ff @(posedge CLK_I) begin
    st_ff <= nxt_st;
  end

  assign RD_VALID_O   = st_ff.rd_v;
  assign RD_DATA_O    = st_ff.rd_d;
  assign OFL_STATUS_O = {st_ff.auto_en, st_ff.code};
  assign SEG_PTR_O    = st_ff.seg;

  AST_DONE_SEG: assert property (@(posedge CLK_I) disable iff (RST_I)
    OFL_STATUS_O[6:0] == OFL_DONE |-> SEG_PTR_O == SEG_TOTAL)
    else $error("done reported with segments outstanding");
  AST_AUTO_BIT: assert property (@(posedge CLK_I) disable iff (RST_I)
    ##1 OFL_STATUS_O[OFL_AUTO_BIT] == $past(AUTO_EN_I))
    else $error("auto collection bit wrong");
  AST_START_BUSY: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_ff.st != HARE_RUN && OFL_START_I |=> OFL_STATUS_O[6:0] == OFL_BUSY)
    else $error("start did not report in progress");
  AST_FATAL_CODE: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_ff.st == HARE_RUN && OFL_FATAL_I |=> OFL_STATUS_O[6:0] == OFL_ABORT_ERR)
    else $error("fatal abort not reported");
  AST_RSVD_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && RD_ADDR_I >= 9'(TABLE_FIRST_BYTE) && RD_ADDR_I <= 9'(TABLE_LAST_BYTE)
    && ((RD_ADDR_I - 9'(TABLE_FIRST_BYTE)) % 9'(ENTRY_BYTES)) == 9'(POS_RSVD)
    |=> RD_VALID_O && RD_DATA_O == RSVD_BYTE)
    else $error("reserved entry byte not zero");
  AST_FLAG_HI_RSVD: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && RD_ADDR_I >= 9'(TABLE_FIRST_BYTE) && RD_ADDR_I <= 9'(TABLE_LAST_BYTE)
    && ((RD_ADDR_I - 9'(TABLE_FIRST_BYTE)) % 9'(ENTRY_BYTES)) == 9'(POS_FLAG_HI)
    |=> RD_DATA_O[7:6] == 2'h0 && RD_DATA_O[7:0] == 8'h00)
    else $error("reserved flag bits set");
  AST_ID_FIRST: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && RD_ADDR_I == 9'(TABLE_FIRST_BYTE) |=> RD_DATA_O == SUP_IDS[0])
    else $error("first identifier wrong");
  AST_RD_VALID: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I |=> RD_VALID_O)
    else $error("read request not answered");
  AST_RD_QUIET: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RD_I |=> !RD_VALID_O)
    else $error("read valid without request");
  AST_OUTSIDE_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && (RD_ADDR_I < 9'(TABLE_FIRST_BYTE) || RD_ADDR_I > 9'(TABLE_LAST_BYTE))
    |=> RD_DATA_O == RSVD_BYTE)
    else $error("byte outside attribute table not zero");
  // entries past the supported set must look unused to the host
  AST_UNSUP_ZERO: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && RD_ADDR_I >= 9'(TABLE_FIRST_BYTE + ENTRY_BYTES * NUM_SUPPORTED)
    && RD_ADDR_I <= 9'(TABLE_LAST_BYTE)
    |=> RD_DATA_O == ID_UNUSED)
    else $error("entry beyond supported set not empty");
  // stray segment or abort pulses outside a run must not move the pointer
  AST_SEG_IDLE: assert property (@(posedge CLK_I) disable iff (RST_I)
    st_ff.st != HARE_RUN && !OFL_START_I |=> $stable(SEG_PTR_O))
    else $error("segment pointer moved while idle");
endmodule // hare_top
`default_nettype wire

// file: hdl/hare_pkg.sv
// package: constants for the attribute record encoder
// assumes: single 25 MHz clock, synchronous active-high reset
`default_nettype none
package hare_pkg;
  localparam int ENTRY_BYTES          = 12;
  localparam int MAX_ENTRIES          = 30;
  localparam int TABLE_FIRST_BYTE     = 2;
  localparam int TABLE_LAST_BYTE      = 361;
  localparam int NUM_SUPPORTED        = 19;
  // entry field positions (byte index within entry)
  localparam int POS_ID               = 0;
  localparam int POS_FLAG_LO          = 1;
  localparam int POS_FLAG_HI          = 2;
  localparam int POS_NORM             = 3;
  localparam int POS_WORST            = 4;
  localparam int POS_RAW_LO           = 5;
  localparam int POS_RAW_HI           = 10;
  localparam int POS_RSVD             = 11;
  localparam int RAW_BYTES            = 6;
  // flag bits
  localparam int FLAG_PREFAIL         = 0;
  localparam int FLAG_ONLINE          = 1;
  localparam int FLAG_PERF            = 2;
  localparam int FLAG_ERRRATE         = 3;
  localparam int FLAG_EVENT           = 4;
  localparam int FLAG_SELFPRES        = 5;
  localparam logic [15:0] FLAG_USED_MASK = 16'h003F;
  // normalized value codes
  localparam logic [7:0] NORM_MIN     = 8'h01;
  localparam logic [7:0] NORM_MAX     = 8'hFD;
  localparam logic [7:0] NORM_INIT    = 8'h64;
  localparam logic [7:0] NORM_UNUSED  = 8'h00;
  localparam logic [7:0] WORST_MAX    = 8'hFE;
  localparam logic [7:0] ID_UNUSED    = 8'h00;
  localparam logic [7:0] RSVD_BYTE    = 8'h00;
  localparam logic [47:0] RAW_SAT     = 48'hFFFF_FFFF_FFFF;
  // off-line status
  localparam int OFL_AUTO_BIT         = 7;
  localparam logic [6:0] OFL_NEVER    = 7'h00;
  localparam logic [6:0] OFL_DONE     = 7'h02;
  localparam logic [6:0] OFL_BUSY     = 7'h03;
  localparam logic [6:0] OFL_SUSP     = 7'h04;
  localparam logic [6:0] OFL_ABORT_CMD = 7'h05;
  localparam logic [6:0] OFL_ABORT_ERR = 7'h06;
  localparam logic [7:0] SEG_TOTAL_DEF = 8'h01;
  localparam logic [7:0] SEG_ZERO     = 8'h00;
  localparam logic [7:0] ONE8         = 8'h01;
  // supported identifiers, one per counter slot
  localparam logic [7:0] SUP_IDS [NUM_SUPPORTED] = '{
    8'h05, 8'h09, 8'h0C, 8'hB1, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8,
    8'hBB, 8'hBE, 8'hC3, 8'hC7, 8'hCA, 8'hEB, 8'hF1, 8'hF2, 8'hFA};
  typedef enum logic [1:0] {HARE_IDLE, HARE_RUN, HARE_HOLD} hare_ofl_st_t;
endpackage : hare_pkg
`default_nettype wire

// file: hdl/hare_slot.sv
// one attribute slot: raw counter, normalized and worst values
// assumes: update strobes synchronous to CLK_I, one per event
`default_nettype none
module hare_slot
  import hare_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        raw_inc_i,
  input  wire logic        norm_wr_i,
  input  wire logic [7:0]  norm_i,
  output logic [47:0]      raw_o,
  output logic [7:0]       norm_o,
  output logic [7:0]       worst_o
);
  typedef struct packed {
    logic [47:0] raw;
    logic [7:0]  norm;
    logic [7:0]  worst;
  } hare_slot_st_t;

  hare_slot_st_t st_ff;
  hare_slot_st_t nxt_st;
  logic [7:0]    clip;

  always_comb begin
    nxt_st = st_ff;
    clip   = norm_i;
    // out-of-range writes are clamped rather than dropped
    if (clip < NORM_MIN) clip = NORM_MIN;
    if (clip > NORM_MAX) clip = NORM_MAX;
    // counter sticks at all ones once saturated
    if (raw_inc_i && (st_ff.raw != RAW_SAT)) nxt_st.raw = st_ff.raw + 48'h1;
    if (norm_wr_i) begin
      nxt_st.norm = clip;
      if (clip < st_ff.worst) nxt_st.worst = clip;
    end
    if (rst_i) begin
      nxt_st.raw   = '0;
      nxt_st.norm  = NORM_INIT;
      nxt_st.worst = NORM_INIT;
    end
  end

  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  assign raw_o   = st_ff.raw;
  assign norm_o  = st_ff.norm;
  assign worst_o = st_ff.worst;

  AST_WORST_NEVER_RISES: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 !$past(rst_i) |-> worst_o <= $past(worst_o))
    else $error("worst value rose");
  AST_NORM_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    norm_o >= NORM_MIN && norm_o <= NORM_MAX)
    else $error("normalized value out of range");
  AST_WORST_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    worst_o >= NORM_MIN && worst_o <= WORST_MAX && worst_o >= 8'h01)
    else $error("worst value out of range");
  AST_RAW_SAT: assert property (@(posedge clk_i) disable iff (rst_i)
    raw_o == RAW_SAT |=> raw_o == RAW_SAT)
    else $error("saturated raw counter moved");
  AST_RAW_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    raw_inc_i && raw_o != RAW_SAT |=> raw_o == $past(raw_o) + 48'h1)
    else $error("raw counter missed an increment");
endmodule // hare_slot
`default_nettype wire

// file: sim/hare_host.sv
// host model: fetches one health structure byte per request
// assumes: the reader answers with a valid pulse after the request edge
`default_nettype none
module hare_host (
  input  wire logic       clk_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            rd_o,
  output logic [8:0]      addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd_o   = 1'b0;
    addr_o = 9'h1FF;
  end
  // request held across one rising edge, moved only at falling edges
  task automatic fetch(input logic [8:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge clk_i);
    rd_o   = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;  // stale address would hide a latch on the wrong edge
    for (int i = 0; i < 4 && !ok; i++) begin
      if (valid_i === 1'b1) begin
        d  = data_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask
  function automatic logic entry_active(input logic [7:0] id);
    return id !== 8'h00;
  endfunction
endmodule : hare_host
`default_nettype wire

// file: sim/hare_top_tb.sv
// bench: reads the health structure and drives counters and off-line events
// assumes: hare_pkg compiled first; inputs change at falling edges
`default_nettype none
module hare_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hare_pkg::*;
  logic                     clk;
  logic                     rst;
  logic [NUM_SUPPORTED-1:0] inc;
  logic [NUM_SUPPORTED-1:0] nwr;
  logic [7:0]               nv;
  logic                     auto_en;
  logic [4:0]               ev;
  logic                     rd;
  logic [8:0]               addr;
  logic                     valid;
  logic [7:0]               data;
  logic [7:0]               status;
  logic [7:0]               seg;
  int                       n_errors;
  int                       n_checks;
  hare_top #(.SEG_TOTAL(8'h02), .SLOT_FLAGS({NUM_SUPPORTED{16'hFFC5}})) u_hare_top (
    .CLK_I(clk), .RST_I(rst), .RAW_INC_I(inc), .NORM_WR_I(nwr), .NORM_I(nv),
    .AUTO_EN_I(auto_en), .OFL_START_I(ev[0]), .OFL_SEG_DONE_I(ev[1]),
    .OFL_SUSPEND_I(ev[2]), .OFL_ABORT_CMD_I(ev[3]), .OFL_FATAL_I(ev[4]),
    .RD_I(rd), .RD_ADDR_I(addr), .RD_VALID_O(valid), .RD_DATA_O(data),
    .OFL_STATUS_O(status), .SEG_PTR_O(seg));
  hare_host u_hare_host (.clk_i(clk), .valid_i(valid), .data_i(data), .rd_o(rd), .addr_o(addr));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_hare_host.fetch(a, d, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH at %0t: no answer for address %0h", $time, a);
      close_out();
    end
    check(d, exp);
  endtask
  task automatic ofl_step(input logic [4:0] m, input logic [7:0] es, input logic [7:0] eg);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 5'h00;
    check(status, es);
    check(seg, eg);
  endtask
  task automatic nv_step(input logic [7:0] v, input logic [7:0] en, input logic [7:0] ew);
    @(negedge clk);
    nwr = 19'h00004;
    nv  = v;
    @(negedge clk);
    nwr = '0;
    rd_chk(9'd29, en);
    rd_chk(9'd30, ew);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int         b;
    logic [7:0] d;
    logic       ok;
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    inc = '0;
    nwr = '0;
    nv = 8'h00;
    auto_en = 1'b0;
    ev = 5'h00;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int e = 0; e < MAX_ENTRIES; e++) begin
      b = TABLE_FIRST_BYTE + ENTRY_BYTES * e;
      u_hare_host.fetch(9'(b), d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, (e < NUM_SUPPORTED) ? SUP_IDS[e] : 8'h00);
      check({7'h00, u_hare_host.entry_active(d)}, {7'h00, e < NUM_SUPPORTED});
      if (e < NUM_SUPPORTED) begin
        // flag word 0xFFC5 loses its reserved bits 6-15 on the way out
        rd_chk(9'(b + 1), 8'h05);
        rd_chk(9'(b + 2), 8'h00);
        rd_chk(9'(b + 3), 8'h64);
        rd_chk(9'(b + 4), 8'h64);
        rd_chk(9'(b + 5), 8'h00);
      end
      rd_chk(9'(b + 11), 8'h00);
    end
    rd_chk(9'd0, 8'h00);
    rd_chk(9'd511, 8'h00);
    // raw of the second slot: 259 increments, low byte first
    @(negedge clk);
    inc = 19'h00002;
    repeat (259) @(negedge clk);
    inc = '0;
    rd_chk(9'd19, 8'h03);
    rd_chk(9'd20, 8'h01);
    rd_chk(9'd24, 8'h00);
    nv_step(8'h50, 8'h50, 8'h50);
    nv_step(8'h80, 8'h80, 8'h50);
    nv_step(8'h00, 8'h01, 8'h01);
    nv_step(8'hFF, 8'hFD, 8'h01);
    ofl_step(5'h00, 8'h00, 8'h00);
    auto_en = 1'b1;
    ofl_step(5'h02, 8'h80, 8'h00);
    ofl_step(5'h01, 8'h83, 8'h00);
    ofl_step(5'h02, 8'h83, 8'h01);
    ofl_step(5'h01, 8'h83, 8'h01);
    ofl_step(5'h04, 8'h84, 8'h01);
    ofl_step(5'h01, 8'h83, 8'h01);
    ofl_step(5'h02, 8'h82, 8'h02);
    ofl_step(5'h01, 8'h83, 8'h00);
    ofl_step(5'h08, 8'h85, 8'h00);
    ofl_step(5'h01, 8'h83, 8'h00);
    ofl_step(5'h1C, 8'h86, 8'h00);
    auto_en = 1'b0;
    ofl_step(5'h00, 8'h06, 8'h00);
    // second reset after the fatal abort: slots and tracker return to start values
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(status, 8'h00);
    check(seg, 8'h00);
    check({7'h00, valid}, 8'h00);
    rd_chk(9'd29, 8'h64);
    rd_chk(9'd30, 8'h64);
    rd_chk(9'd19, 8'h00);
    close_out();
  end
endmodule : hare_top_tb
`default_nettype wire
